/* File: verilog/converter_pkg.sv */
/*
 * Shared constants, types and register map of the converter input path.
 * Assumes a classic Wishbone slave port with 32-bit data and a 10 MHz clock.
 */
// Functional notes
// [RQ1] right alignment: low holds value 7..0, high bits 1..0 hold 9..8
// [RQ2] left alignment: high holds value 9..2, low bits 7..6 hold 1..0
// [RQ3] a low write alone never transfers a value until high is written
// [RQ4] converter reads only hidden shadow value, loaded whole in one edge
// [RQ5] manual mode: high write loads shadow from high and low at once
// [RQ6] auto mode: shadow loads on the selected trigger event, not the write
// [RQ7] auto mode: trigger loads only a pair completed by the high write
// [RQ8] auto mode with high-only writes: every trigger event loads shadow; the code loads only on edges that find the converter idle
// [RQ9] low change alone leaves the converted value unchanged in both modes
// [RQ10] software writes low first, then high; high alone for 8-bit use
// [RQ11] auto update starts on rising edge of the selected trigger flag
// [RQ12] edges during conversion ignored; held-high trigger starts nothing
// [RQ13] three-bit source field picks one of eight trigger sources
// [RQ14] alignment change reaches the output only at the next high write
// [RQ15] high and low read back as last written, never the shadow value
package converter_pkg;

    // ------------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [3:0] CONTROL_OFFSET = 4'h0;
    localparam logic [3:0] HIGH_OFFSET    = 4'h4;
    localparam logic [3:0] LOW_OFFSET     = 4'h8;
    localparam logic [3:0] STATUS_OFFSET  = 4'hC;

    // control register bit positions
    localparam int AUTO_TRIGGER_BIT = 7;
    localparam int SOURCE_MSB       = 6;
    localparam int SOURCE_LSB       = 4;
    localparam int LEFT_ALIGN_BIT   = 2;
    localparam int DRIVE_ENABLE_BIT = 1;
    localparam int ENABLE_BIT       = 0;

    // status register bit positions
    localparam int LOW_PENDING_BIT  = 0;
    localparam int BUSY_BIT         = 1;
    localparam int STAGED_FRESH_BIT = 2;
    localparam int EDGE_IGNORED_BIT = 3;

    // reset values
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] HIGH_RESET    = 8'h00;
    localparam logic [7:0] LOW_RESET     = 8'h00;
    localparam logic [9:0] VALUE_RESET   = 10'h000;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS      = 100;
    localparam int CONVERSION_TIME_NS = 1000;
    // least time, so rounded up to whole cycles
    localparam int CONVERSION_CYCLES =
        (CONVERSION_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] CONVERSION_LAST =
        4'(CONVERSION_CYCLES - 1);

    // ------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        SRC_COMPARATOR0    = 3'h0,
        SRC_COMPARATOR1    = 3'h1,
        SRC_EXT_INTERRUPT0 = 3'h2,
        SRC_TIMER0_COMPARE = 3'h3,
        SRC_TIMER0_OVERFLOW = 3'h4,
        SRC_TIMER1_COMPARE_B = 3'h5,
        SRC_TIMER1_OVERFLOW = 3'h6,
        SRC_TIMER1_CAPTURE = 3'h7
    } trigger_source_t;

    typedef struct packed {
        logic            auto_trigger_enable;
        trigger_source_t trigger_source_select;
        logic            reserved_zero;
        logic            left_align_select;
        logic            drive_enable;
        logic            enable;
    } control_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } wb_req_t;

    typedef enum logic [1:0] {
        REG_CONTROL = 2'h0,
        REG_HIGH    = 2'h1,
        REG_LOW     = 2'h2,
        REG_STATUS  = 2'h3
    } reg_id_t;

    typedef enum logic {
        CONV_IDLE = 1'b0,
        CONV_RUN  = 1'b1
    } conv_state_t;

endpackage

/* File: verilog/trigger_edge_select.sv */
/*
 * Rising-edge detector on the selected trigger flag.
 * Assumes flags are synchronous to clk_i; output is a registered pulse.
 */
`timescale 1ns/1ps
module trigger_edge_select (
    input  wire logic                         clk_i,
    input  wire logic                         rst_i,
    input  wire logic [7:0]                   flags_i,
    input  wire converter_pkg::trigger_source_t select_i,
    output logic                              rise_o
);
    // history of every flag, so a source change does not fake an edge
    logic [7:0] flags_prev;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags_prev <= 8'h00;
        end else begin
            flags_prev <= flags_i;
        end
    end

    // edge only: a flag that stays high gives no second pulse
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rise_o <= 1'b0;
        end else begin
            rise_o <= flags_i[select_i] & ~flags_prev[select_i]; // [RQ11]
        end
    end
endmodule // trigger_edge_select

/* File: verilog/dac_input_shadow_update.sv */
/*
 * Input data path of the 10-bit converter: control, high and low data
 * registers, alignment, hidden shadow value and trigger-driven update.
 * Assumes a classic Wishbone master, synchronous trigger flags from the
 * comparators, external interrupt and timers, and an analog core that
 * takes converted_value_o whenever it changes.
 */
`timescale 1ns/1ps
module dac_input_shadow_update (
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    input  wire converter_pkg::wb_req_t wb_i,
    output logic                        wb_ack_o,
    output logic [31:0]                 wb_dat_o,
    input  wire logic [7:0]             trigger_flags_i,
    output logic [9:0]                  converted_value_o,
    output logic                        converter_enable_o,
    output logic                        output_drive_enable_o,
    output logic                        value_load_o,
    output logic                        conversion_busy_o
);

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    function automatic logic decode_hit(
        input logic [3:0] adr,
        output converter_pkg::reg_id_t id
    );
        logic hit;
        hit = 1'b1;
        id  = converter_pkg::REG_CONTROL;
        unique case (adr)
            converter_pkg::CONTROL_OFFSET: id = converter_pkg::REG_CONTROL;
            converter_pkg::HIGH_OFFSET:    id = converter_pkg::REG_HIGH;
            converter_pkg::LOW_OFFSET:     id = converter_pkg::REG_LOW;
            converter_pkg::STATUS_OFFSET:  id = converter_pkg::REG_STATUS;
            default:                       hit = 1'b0;
        endcase
        return hit;
    endfunction

    // value as seen by the analog core for the given alignment
    function automatic logic [9:0] assemble(
        input logic [7:0] high,
        input logic [7:0] low,
        input logic       left
    );
        logic [9:0] v;
        if (left) begin
            v = {high, low[7:6]};                            // [RQ2]
        end else begin
            v = {high[1:0], low};                            // [RQ1]
        end
        return v;
    endfunction

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    converter_pkg::control_t    control;
    logic [7:0]                 value_high;
    logic [7:0]                 value_low;
    logic [9:0]                 staged_value;
    logic                       staged_fresh;
    logic                       low_pending;
    logic                       edge_ignored;
    converter_pkg::conv_state_t conv_state;
    logic [3:0]                 conv_count;
    logic                       trigger_rise;

    converter_pkg::reg_id_t     req_id;
    logic                       req_hit;
    logic                       req_active;
    logic                       wr_fire;
    logic                       wr_lane0;
    logic [7:0]                 wr_byte;
    logic                       write_control;
    logic                       write_high;
    logic                       write_low;
    logic                       write_status;
    logic                       load_now;
    logic [9:0]                 next_value;
    logic [9:0]                 next_staged;
    logic [31:0]                read_word;

    // ------------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------------
    always_comb begin
        req_hit = decode_hit(wb_i.adr, req_id);
    end

    assign req_active = wb_i.cyc & wb_i.stb;
    // a write acts at the edge that also sees ack high
    assign wr_fire  = req_active & wb_i.we & wb_ack_o & req_hit;
    assign wr_lane0 = wr_fire & wb_i.sel[0];
    assign wr_byte  = wb_i.dat[7:0];

    assign write_control = wr_lane0 && req_id == converter_pkg::REG_CONTROL;
    assign write_high    = wr_lane0 && req_id == converter_pkg::REG_HIGH;
    assign write_low     = wr_lane0 && req_id == converter_pkg::REG_LOW;
    assign write_status  = wr_lane0 && req_id == converter_pkg::REG_STATUS;

    // one-cycle ack, dropped the cycle after; unmapped reads give zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req_active & ~wb_ack_o;
        end
    end

    always_comb begin
        read_word = 32'h0000_0000;
        if (req_hit) begin
            unique case (req_id)
                converter_pkg::REG_CONTROL: read_word[7:0] = control;
                converter_pkg::REG_HIGH:    read_word[7:0] = value_high;
                converter_pkg::REG_LOW:     read_word[7:0] = value_low;
                converter_pkg::REG_STATUS: begin
                    read_word[converter_pkg::LOW_PENDING_BIT]  = low_pending;
                    read_word[converter_pkg::BUSY_BIT] =
                        conv_state == converter_pkg::CONV_RUN;
                    read_word[converter_pkg::STAGED_FRESH_BIT] = staged_fresh;
                    read_word[converter_pkg::EDGE_IGNORED_BIT] = edge_ignored;
                end
            endcase
        end
    end

    // data registers read back, never the hidden shadow
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (req_active & ~wb_ack_o & ~wb_i.we) begin
            wb_dat_o <= read_word;                           // [RQ15]
        end
    end

    // ------------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            control <= converter_pkg::CONTROL_RESET;
        end else if (write_control) begin
            control <= {wr_byte[7:4], 1'b0,
                        wr_byte[2:0]};                       // [RQ13]
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            value_high <= converter_pkg::HIGH_RESET;
        end else if (write_high) begin
            value_high <= wr_byte;
        end
    end

    // a low write lands here only; nothing downstream sees it yet
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            value_low <= converter_pkg::LOW_RESET;
        end else if (write_low) begin
            value_low <= wr_byte;                            // [RQ3] [RQ9]
        end
    end

    // informational: a low write still waiting for its high partner
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            low_pending <= 1'b0;
        end else if (write_low) begin
            low_pending <= 1'b1;
        end else if (write_high) begin
            low_pending <= 1'b0;                             // [RQ10]
        end
    end

    // ------------------------------------------------------------------
    // staging: the pair completed by a high write
    // ------------------------------------------------------------------
    // alignment is sampled here, so a later change waits for a high write
    assign next_staged =
        assemble(wr_byte, value_low, control.left_align_select); // [RQ14]

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            staged_value <= converter_pkg::VALUE_RESET;
        end else if (write_high) begin
            staged_value <= next_staged;                     // [RQ7]
        end
    end

    // freshness is reported only; an old pair still reloads on each trigger
    // edge that finds the converter idle, which gives plain 8-bit use without rewriting
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            staged_fresh <= 1'b0;
        end else if (write_high) begin
            staged_fresh <= 1'b1;
        end else if (load_now) begin
            staged_fresh <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // trigger
    // ------------------------------------------------------------------
    trigger_edge_select u_trigger (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .flags_i  (trigger_flags_i),
        .select_i (control.trigger_source_select),
        .rise_o   (trigger_rise)
    );

    // manual mode loads on the high write itself, auto mode on an edge
    // that finds the converter idle
    always_comb begin
        load_now   = 1'b0;
        next_value = converted_value_o;
        if (!control.auto_trigger_enable) begin
            if (write_high) begin
                load_now   = 1'b1;                           // [RQ5]
                next_value = next_staged;
            end
        end else if (trigger_rise &&
                     conv_state == converter_pkg::CONV_IDLE) begin
            load_now   = 1'b1;                               // [RQ6] [RQ8]
            next_value = staged_value;
        end
    end

    // edge seen while busy is dropped; flag stays until written with one
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            edge_ignored <= 1'b0;
        end else if (control.auto_trigger_enable && trigger_rise &&
                     conv_state == converter_pkg::CONV_RUN) begin
            edge_ignored <= 1'b1;                            // [RQ12]
        end else if (write_status &&
                     wr_byte[converter_pkg::EDGE_IGNORED_BIT]) begin
            edge_ignored <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // conversion timing
    // ------------------------------------------------------------------
    // a trigger still high at the end gives no new edge, so no restart
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            conv_state <= converter_pkg::CONV_IDLE;
            conv_count <= 4'h0;
        end else begin
            unique case (conv_state)
                converter_pkg::CONV_IDLE: begin
                    conv_count <= 4'h0;
                    if (load_now) begin
                        conv_state <= converter_pkg::CONV_RUN;
                    end
                end
                converter_pkg::CONV_RUN: begin
                    if (load_now) begin
                        conv_count <= 4'h0;
                    end else if (conv_count ==
                                 converter_pkg::CONVERSION_LAST) begin
                        conv_state <= converter_pkg::CONV_IDLE; // [RQ12]
                        conv_count <= 4'h0;
                    end else begin
                        conv_count <= conv_count + 4'h1;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // shadow value and outputs
    // ------------------------------------------------------------------
    // the whole 10-bit word changes in one edge, never half of it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            converted_value_o <= converter_pkg::VALUE_RESET;
        end else begin
            converted_value_o <= next_value;                 // [RQ4]
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            value_load_o <= 1'b0;
        end else begin
            value_load_o <= load_now;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            conversion_busy_o <= 1'b0;
        end else begin
            conversion_busy_o <= load_now ||
                (conv_state == converter_pkg::CONV_RUN &&
                 conv_count != converter_pkg::CONVERSION_LAST);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            converter_enable_o    <= 1'b0;
            output_drive_enable_o <= 1'b0;
        end else begin
            converter_enable_o    <= control.enable;
            output_drive_enable_o <= control.drive_enable;
        end
    end

endmodule // dac_input_shadow_update

/* File: dv/dac_input_shadow_update_assertions.sv */
/*
 * Concurrent checks on the ports of the converter input path.
 * Assumes one clock, synchronous active-high reset, classic Wishbone.
 */
`timescale 1ns/1ps
module dac_input_shadow_update_checker (
    input wire logic                   clk_i,
    input wire logic                   rst_i,
    input wire converter_pkg::wb_req_t wb_i,
    input wire logic                   wb_ack_o,
    input wire logic [31:0]            wb_dat_o,
    input wire logic [7:0]             trigger_flags_i,
    input wire logic [9:0]             converted_value_o,
    input wire logic                   converter_enable_o,
    input wire logic                   output_drive_enable_o,
    input wire logic                   value_load_o,
    input wire logic                   conversion_busy_o
);
    localparam int BUSY_MAX = converter_pkg::CONVERSION_CYCLES + 2;
    logic       hit;
    logic       auto_q;
    logic [2:0] auto_h;
    logic [2:0] hw_h;
    logic [3:0] rise_h;
    logic [7:0] flags_d;
    logic [4:0] busy_cnt;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ------------------------------------------------------------------
    // helper state
    // ------------------------------------------------------------------
    assign hit = wb_i.cyc & wb_i.stb & wb_ack_o & wb_i.we & wb_i.sel[0];
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            auto_q <= 1'b0;
        end else if (hit && wb_i.adr == converter_pkg::CONTROL_OFFSET) begin
            auto_q <= wb_i.dat[converter_pkg::AUTO_TRIGGER_BIT];
        end
    end
    // histories kept wide so pipeline depth guesses stay loose
    always_ff @(posedge clk_i) begin
        auto_h  <= {auto_h[1:0], auto_q};
        hw_h    <= {hw_h[1:0], hit && wb_i.adr == converter_pkg::HIGH_OFFSET};
        flags_d <= trigger_flags_i;
        rise_h  <= {rise_h[2:0], |(trigger_flags_i & ~flags_d)};
    end
    always_ff @(posedge clk_i) begin
        if (rst_i || value_load_o || !conversion_busy_o) begin
            busy_cnt <= 5'h00;
        end else begin
            busy_cnt <= busy_cnt + 5'h01;
        end
    end
    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    chk_ack_one_cycle: assert property (
        wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
    chk_ack_answers_req: assert property (
        wb_i.cyc && wb_i.stb && !wb_ack_o |=> wb_ack_o)
        else $error("request not acked");
    chk_value_needs_load: assert property (
        !$stable(converted_value_o) |-> value_load_o)
        else $error("value changed without load");
    chk_busy_after_load: assert property (
        value_load_o |=> conversion_busy_o [*8])
        else $error("busy missing after load");
    chk_busy_bounded: assert property (
        busy_cnt <= BUSY_MAX) else $error("busy too long");
    chk_manual_high_load: assert property (
        hit && wb_i.adr == converter_pkg::HIGH_OFFSET && !auto_q
        && auto_h == 3'h0 |-> ##[1:2] value_load_o)
        else $error("high write did not load");
    chk_manual_load_cause: assert property (
        value_load_o && !auto_q && auto_h == 3'h0 |-> hw_h != 3'h0)
        else $error("manual load without high write");
    chk_auto_edge_cause: assert property (
        value_load_o && auto_q && auto_h == 3'h7 |-> rise_h != 4'h0)
        else $error("auto load without trigger edge");
endmodule // dac_input_shadow_update_checker

bind dac_input_shadow_update dac_input_shadow_update_checker u_chk (
    .clk_i                 (clk_i),
    .rst_i                 (rst_i),
    .wb_i                  (wb_i),
    .wb_ack_o              (wb_ack_o),
    .wb_dat_o              (wb_dat_o),
    .trigger_flags_i       (trigger_flags_i),
    .converted_value_o     (converted_value_o),
    .converter_enable_o    (converter_enable_o),
    .output_drive_enable_o (output_drive_enable_o),
    .value_load_o          (value_load_o),
    .conversion_busy_o     (conversion_busy_o)
);

/* File: dv/dac_input_shadow_update_tb_top.sv */
/*
 * Self-checking bench for the converter input path: register accesses,
 * manual and triggered updates, all eight trigger sources.
 * Assumes the checker file is compiled alongside.
 */
`timescale 1ns/1ps
module dac_input_shadow_update_tb_top;
    logic                   clk_i;
    logic                   rst_i;
    converter_pkg::wb_req_t wb_i;
    logic                   wb_ack_o;
    logic [31:0]            wb_dat_o;
    logic [7:0]             trigger_flags_i;
    logic [9:0]             converted_value_o;
    logic                   converter_enable_o;
    logic                   output_drive_enable_o;
    logic                   value_load_o;
    logic                   conversion_busy_o;
    int                     err_total = 0;
    int                     checked = 0;
    int                     loads = 0;
    int                     l0;
    logic [31:0]            rd;
    logic [9:0]             prev;
    dac_input_shadow_update u_dut (
        .clk_i                 (clk_i),
        .rst_i                 (rst_i),
        .wb_i                  (wb_i),
        .wb_ack_o              (wb_ack_o),
        .wb_dat_o              (wb_dat_o),
        .trigger_flags_i       (trigger_flags_i),
        .converted_value_o     (converted_value_o),
        .converter_enable_o    (converter_enable_o),
        .output_drive_enable_o (output_drive_enable_o),
        .value_load_o          (value_load_o),
        .conversion_busy_o     (conversion_busy_o)
    );
    initial clk_i = 1'b0;
    always #50 clk_i = ~clk_i;
    always @(posedge clk_i) if (value_load_o === 1'b1) loads <= loads + 1;
    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic xfer(input logic w, input logic [3:0] a,
                        input logic [7:0] d);
        wb_i <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hF,
                  dat: {24'h000000, d}};
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_i <= '0;
        @(posedge clk_i);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 8'h00);
        chk(rd, exp);
    endtask
    // fixed wait covers the whole conversion window
    task automatic settle;
        repeat (14) @(posedge clk_i);
    endtask
    task automatic conv_chk(input logic [9:0] exp);
        chk({22'h0, converted_value_o}, {22'h0, exp});
    endtask
    task automatic pulse(input int i);
        trigger_flags_i[i] <= 1'b1;
        repeat (2) @(posedge clk_i);
        trigger_flags_i[i] <= 1'b0;
        @(posedge clk_i);
    endtask
    task tally_and_finish;
        $display("checks %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    initial begin
        rst_i = 1'b1;
        wb_i = '0;
        trigger_flags_i = 8'h00;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd_chk(converter_pkg::CONTROL_OFFSET, 32'h00000000);
        rd_chk(converter_pkg::HIGH_OFFSET, 32'h00000000);
        rd_chk(converter_pkg::LOW_OFFSET, 32'h00000000);
        xfer(1'b1, 4'h1, 8'hFF);
        rd_chk(4'h1, 32'h00000000);
        conv_chk(10'h000);
        l0 = loads;
        xfer(1'b1, converter_pkg::LOW_OFFSET, 8'hA5);
        settle();
        conv_chk(10'h000);
        chk(32'(loads - l0), 32'h00000000);
        xfer(1'b1, converter_pkg::HIGH_OFFSET, 8'h03);
        settle();
        conv_chk(10'h3A5);
        chk(32'(loads - l0), 32'h00000001);
        rd_chk(converter_pkg::HIGH_OFFSET, 32'h00000003);
        rd_chk(converter_pkg::LOW_OFFSET, 32'h000000A5);
        xfer(1'b1, converter_pkg::CONTROL_OFFSET, 8'h0E);
        settle();
        conv_chk(10'h3A5);
        chk({30'h0, converter_enable_o, output_drive_enable_o},
            32'h00000001);
        rd_chk(converter_pkg::CONTROL_OFFSET, 32'h00000006);
        xfer(1'b1, converter_pkg::HIGH_OFFSET, 8'hC3);
        settle();
        conv_chk(10'h30E);
        xfer(1'b1, converter_pkg::LOW_OFFSET, 8'h40);
        settle();
        conv_chk(10'h30E);
        xfer(1'b1, converter_pkg::HIGH_OFFSET, 8'h80);
        settle();
        conv_chk(10'h201);
        prev = 10'h201;
        // every source: stage, stray edge, then a long high level
        for (int s = 0; s < 8; s++) begin
            xfer(1'b1, converter_pkg::CONTROL_OFFSET, {1'b1, 3'(s), 4'h4});
            xfer(1'b1, converter_pkg::HIGH_OFFSET, {4'(s), 4'h1});
            l0 = loads;
            settle();
            conv_chk(prev);
            pulse((s + 1) % 8);
            settle();
            chk(32'(loads - l0), 32'h00000000);
            trigger_flags_i[s] <= 1'b1;
            repeat (2) settle();
            chk(32'(loads - l0), 32'h00000001);
            prev = {4'(s), 4'h1, 2'b01};
            conv_chk(prev);
            trigger_flags_i[s] <= 1'b0;
            @(posedge clk_i);
        end
        xfer(1'b1, converter_pkg::LOW_OFFSET, 8'hC0);
        pulse(7);
        settle();
        conv_chk(prev);
        xfer(1'b1, converter_pkg::HIGH_OFFSET, 8'h22);
        pulse(7);
        settle();
        conv_chk(10'h08B);
        l0 = loads;
        pulse(7);
        settle();
        pulse(7);
        settle();
        chk(32'(loads - l0), 32'h00000002);
        l0 = loads;
        pulse(7);
        pulse(7);
        settle();
        chk(32'(loads - l0), 32'h00000001);
        rd_chk(converter_pkg::LOW_OFFSET, 32'h000000C0);
        xfer(1'b0, converter_pkg::STATUS_OFFSET, 8'h00);
        chk({31'h0, rd[converter_pkg::EDGE_IGNORED_BIT]},
            32'h00000001);
        tally_and_finish();
    end
    initial begin
        repeat (5000) @(posedge clk_i);
        err_total++;
        tally_and_finish();
    end
endmodule // dac_input_shadow_update_tb_top
